// File: hdl/crm_cfg.svh
// Constants for the clock and reset manager
`ifndef CRM_CFG_SVH
`define CRM_CFG_SVH

// Slow source select encodings
`define CRM_SRC_RC 1'b0
`define CRM_SRC_XTAL 1'b1
`define CRM_SRC_RESET `CRM_SRC_RC

// Reset cause record field positions
`define CRM_CAUSE_PIN 0
`define CRM_CAUSE_WDOG 1
`define CRM_CAUSE_SOFT 2
`define CRM_CAUSE_WAKE 3
`define CRM_CAUSE_W 4
`define CRM_CAUSE_RESET 4'h0

// Timing
`define CRM_CLK_MHZ 25
`define CRM_POR_HOLD_NS 1000
`define CRM_POR_CYCLES ((`CRM_POR_HOLD_NS * `CRM_CLK_MHZ + 999) / 1000)
`define CRM_RST_PULSE_CYCLES 4

`endif

// File: hdl/crm_clock_reset_manager.sv
// Clock source control and reset generation
//
// Operation
// - Fast clocks gated by each request
// - No request turns internal fast osc off
// - Internal osc used unless crystal stable
// - Crystal start, stop tasks; ready event
// - System OFF powers slow domain down
// - Old RC source runs until crystal ready
// - Switch stretches pulse, never glitches
// - Watchdog running starts RC source
// - Slow ready event when source started
// - RC quality until crystal stable
// - Stop task drops only global request
// - Source select resets to RC
// - Reset cause recorded for software
// - Power-on holds reset until supply good
// - Low reset pin causes reset
// - Wakeup from System OFF resets
// - Debug mode keeps debug port on wakeup
// - Soft reset from reset request bit
// - Watchdog reset, absent in System OFF
// - Brownout level differs by power mode
// - Causes accumulate, write one clears
`timescale 1ns/1ps
`default_nettype none
`include "crm_cfg.svh"

module crm_clock_reset_manager (
	input wire logic core_clk, // System clock, 25 MHz
	input wire logic rst, // Synchronous reset, high
	input wire crm_pkg::crm_fast_req_t fastReq, // Fast clock requests
	input wire logic fastCrystalStartTask, // Crystal start pulse
	input wire logic fastCrystalStopTask, // Crystal stop pulse
	input wire logic fastCrystalStable, // Crystal settled, async
	input wire logic slowClockStartTask, // Slow start pulse
	input wire logic slowClockStopTask, // Slow stop pulse
	input wire logic slowSourceSelectWr, // Write strobe for select
	input wire logic slowSourceSelectIn, // New select value
	input wire logic slowRcReady, // RC source up, async
	input wire logic slowXtalReady, // Crystal source up, async
	input wire logic slowRcTick, // RC clock level, async
	input wire logic slowXtalTick, // Crystal clock level, async
	input wire logic watchdogRunning, // Watchdog is active
	input wire logic modemNeedsSlow, // Modem needs slow clock
	input wire logic systemOff, // System OFF mode
	input wire logic debugMode, // Debug interface mode
	input wire logic supplyGood, // Supply above minimum, async
	input wire logic regulatorsUp, // Regulators started, async
	input wire logic brownoutActive, // Below active level, async
	input wire logic brownoutSleep, // Below sleep level, async
	input wire logic externalResetPinN, // Reset pin, low active
	input wire logic wakeupEvent, // Wakeup from System OFF
	input wire logic systemResetRequestBit, // Soft reset request
	input wire logic watchdogTimeout, // Watchdog expired
	input wire logic [`CRM_CAUSE_W-1:0] causeClear, // Write one to clear
	output logic fastInternalOn_ff, // Internal fast osc enable
	output logic fastCrystalOn_ff, // Crystal fast osc enable
	output crm_pkg::crm_fast_req_t fastGate_ff, // Fast clock gates
	output logic fastCrystalReadyEvent_ff, // Crystal ready pulse
	output logic slowRcOn_ff, // RC source enable
	output logic slowXtalOn_ff, // Crystal source enable
	output logic slowClockOut_ff, // Slow clock output
	output logic slowClockReadyEvent_ff, // Slow ready pulse
	output crm_pkg::crm_slow_stat_t slowClockStatus_ff, // Running and source
	output logic slowSourceSelect_ff, // Current select value
	output logic [`CRM_CAUSE_W-1:0] resetCauseRecord_ff, // Reset causes
	output logic systemReset_ff, // System reset out
	output logic debugReset_ff // Debug port reset out
);

	// -----------------------------------------------------------------
	// Input synchronisers
	// -----------------------------------------------------------------
	localparam int SN = 10;
	logic [SN-1:0] syncA_ff;
	logic [SN-1:0] syncB_ff;
	logic xtalStableS;
	logic rcReadyS;
	logic xReadyS;
	logic rcTickS;
	logic xTickS;
	logic supplyS;
	logic regS;
	logic borOnS;
	logic borOffS;
	logic pinNS;

	// Two flops on every asynchronous level
	always_ff @(posedge core_clk) begin
		syncA_ff <= {fastCrystalStable, slowRcReady, slowXtalReady, slowRcTick, slowXtalTick,
			supplyGood, regulatorsUp, brownoutActive, brownoutSleep, externalResetPinN};
		syncB_ff <= syncA_ff;
	end
	assign {xtalStableS, rcReadyS, xReadyS, rcTickS, xTickS, supplyS, regS, borOnS, borOffS, pinNS} = syncB_ff;

	// -----------------------------------------------------------------
	// Fast clock controller
	// -----------------------------------------------------------------
	logic anyFast;
	logic xtalStableD_ff;
	assign anyFast = |fastReq;

	// Crystal start and stop tasks
	always_ff @(posedge core_clk) begin
		if (rst) begin
			fastCrystalOn_ff <= 1'b0;
		end else if (fastCrystalStartTask) begin
			fastCrystalOn_ff <= 1'b1;
		end else if (fastCrystalStopTask || systemOff) begin
			fastCrystalOn_ff <= 1'b0;
		end
	end

	// Internal osc only when requested and crystal not up
	always_ff @(posedge core_clk) begin
		if (rst) begin
			fastInternalOn_ff <= 1'b0;
		end else begin
			fastInternalOn_ff <= anyFast && !(fastCrystalOn_ff && xtalStableS);
		end
	end

	// Per-clock gates follow each request
	always_ff @(posedge core_clk) begin
		if (rst) begin
			fastGate_ff <= '0;
		end else begin
			fastGate_ff <= fastReq;
		end
	end

	// Ready event once per start, on rising settled level
	always_ff @(posedge core_clk) begin
		if (rst) begin
			xtalStableD_ff <= 1'b0;
			fastCrystalReadyEvent_ff <= 1'b0;
		end else begin
			xtalStableD_ff <= xtalStableS && fastCrystalOn_ff;
			fastCrystalReadyEvent_ff <= xtalStableS && fastCrystalOn_ff && !xtalStableD_ff;
		end
	end

	// -----------------------------------------------------------------
	// Slow clock controller
	// -----------------------------------------------------------------
	crm_pkg::crm_slow_state_t slowState_ff;
	crm_pkg::crm_slow_state_t nxt_slowState;
	logic globalReq_ff;
	logic activeSrc_ff;
	logic targetSrc_ff;
	logic xtalEverStable_ff;
	logic slowNeeded;
	logic targetReady;
	logic stretch_ff;

	// Source select register, default RC
	always_ff @(posedge core_clk) begin
		if (rst) begin
			slowSourceSelect_ff <= `CRM_SRC_RESET;
		end else if (slowSourceSelectWr) begin
			slowSourceSelect_ff <= slowSourceSelectIn;
		end
	end

	// Global request: start sets, stop clears only this
	always_ff @(posedge core_clk) begin
		if (rst || systemOff) begin
			globalReq_ff <= 1'b0;
		end else if (slowClockStartTask) begin
			globalReq_ff <= 1'b1;
		end else if (slowClockStopTask) begin
			globalReq_ff <= 1'b0;
		end
	end

	// Target source latched at start; watchdog alone uses RC
	always_ff @(posedge core_clk) begin
		if (rst) begin
			targetSrc_ff <= `CRM_SRC_RC;
		end else if (slowClockStartTask) begin
			targetSrc_ff <= slowSourceSelect_ff;
		end else if (!globalReq_ff && watchdogRunning) begin
			targetSrc_ff <= `CRM_SRC_RC;
		end
	end

	assign slowNeeded = !systemOff && (globalReq_ff || watchdogRunning || modemNeedsSlow);
	assign targetReady = (targetSrc_ff == `CRM_SRC_XTAL) ? xReadyS : rcReadyS;

	// Slow controller sequencing
	always_comb begin
		nxt_slowState = slowState_ff;
		case (slowState_ff)
			crm_pkg::SLOW_OFF: begin
				if (slowNeeded) begin
					nxt_slowState = crm_pkg::SLOW_WAIT;
				end
			end
			crm_pkg::SLOW_WAIT: begin
				if (!slowNeeded) begin
					nxt_slowState = crm_pkg::SLOW_OFF;
				end else if (rcReadyS || targetReady) begin
					nxt_slowState = crm_pkg::SLOW_RUN;
				end
			end
			crm_pkg::SLOW_RUN: begin
				if (!slowNeeded) begin
					nxt_slowState = crm_pkg::SLOW_OFF;
				end else if (activeSrc_ff != targetSrc_ff && targetReady) begin
					nxt_slowState = crm_pkg::SLOW_SWITCH;
				end
			end
			crm_pkg::SLOW_SWITCH: begin
				if (!slowNeeded) begin
					nxt_slowState = crm_pkg::SLOW_OFF;
				end else if (activeSrc_ff == targetSrc_ff && !stretch_ff) begin
					nxt_slowState = crm_pkg::SLOW_RUN;
				end
			end
			default: nxt_slowState = crm_pkg::SLOW_OFF;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			slowState_ff <= crm_pkg::SLOW_OFF;
		end else begin
			slowState_ff <= nxt_slowState;
		end
	end

	// Source enables; RC kept on as stand-in until crystal stable
	always_ff @(posedge core_clk) begin
		if (rst) begin
			slowRcOn_ff <= 1'b0;
			slowXtalOn_ff <= 1'b0;
			xtalEverStable_ff <= 1'b0;
		end else begin
			slowXtalOn_ff <= slowNeeded && targetSrc_ff == `CRM_SRC_XTAL;
			slowRcOn_ff <= slowNeeded && (targetSrc_ff == `CRM_SRC_RC || activeSrc_ff == `CRM_SRC_RC
				|| !xtalEverStable_ff);
			if (xReadyS) begin
				xtalEverStable_ff <= 1'b1;
			end
		end
	end

	// Active source: hand-over only during a low phase of the old clock
	always_ff @(posedge core_clk) begin
		if (rst) begin
			activeSrc_ff <= `CRM_SRC_RC;
			stretch_ff <= 1'b0;
		end else if (slowState_ff == crm_pkg::SLOW_WAIT) begin
			activeSrc_ff <= targetReady ? targetSrc_ff : `CRM_SRC_RC;
			stretch_ff <= 1'b0;
		end else if (slowState_ff == crm_pkg::SLOW_SWITCH) begin
			if (!stretch_ff && !slowClockOut_ff) begin
				stretch_ff <= 1'b1; // Old clock low: freeze output
			end else if (stretch_ff && !xTickS && !rcTickS) begin
				activeSrc_ff <= targetSrc_ff;
				stretch_ff <= 1'b0;
			end
		end
	end

	// Glitch-free output: held low from a low phase of the old clock until the hand-over
	always_ff @(posedge core_clk) begin
		if (rst) begin
			slowClockOut_ff <= 1'b0;
		end else if (slowState_ff == crm_pkg::SLOW_OFF || slowState_ff == crm_pkg::SLOW_WAIT || stretch_ff) begin
			slowClockOut_ff <= 1'b0;
		end else begin
			slowClockOut_ff <= (activeSrc_ff == `CRM_SRC_XTAL) ? xTickS : rcTickS;
		end
	end

	// Status and ready event on entry to running
	always_ff @(posedge core_clk) begin
		if (rst) begin
			slowClockStatus_ff <= '0;
			slowClockReadyEvent_ff <= 1'b0;
		end else begin
			slowClockStatus_ff.valid <= nxt_slowState != crm_pkg::SLOW_OFF && nxt_slowState != crm_pkg::SLOW_WAIT;
			slowClockStatus_ff.fromXtal <= activeSrc_ff;
			slowClockReadyEvent_ff <= slowState_ff == crm_pkg::SLOW_WAIT
				&& nxt_slowState == crm_pkg::SLOW_RUN;
		end
	end

	// -----------------------------------------------------------------
	// Reset generation
	// -----------------------------------------------------------------
	localparam logic [7:0] POR_CYC = 8'(`CRM_POR_CYCLES);
	localparam logic [7:0] PULSE_CYC = 8'(`CRM_RST_PULSE_CYCLES);
	logic [7:0] porCnt_ff;
	logic [7:0] pulseCnt_ff;
	logic porHold;
	logic brownout;
	logic [`CRM_CAUSE_W-1:0] causeSet;
	logic wakeOnly;
	logic wakeOnly_ff;

	assign brownout = systemOff ? borOffS : borOnS;
	assign porHold = !(supplyS && regS) || brownout;
	assign causeSet[`CRM_CAUSE_PIN] = !pinNS;
	assign causeSet[`CRM_CAUSE_WDOG] = watchdogTimeout && !systemOff;
	assign causeSet[`CRM_CAUSE_SOFT] = systemResetRequestBit;
	assign causeSet[`CRM_CAUSE_WAKE] = wakeupEvent && systemOff;
	assign wakeOnly = causeSet == (`CRM_CAUSE_W'(1) << `CRM_CAUSE_WAKE);

	// Power-on hold counter restarts while supply is not good
	always_ff @(posedge core_clk) begin
		if (rst || porHold) begin
			porCnt_ff <= POR_CYC;
		end else if (porCnt_ff != 8'h00) begin
			porCnt_ff <= porCnt_ff - 8'h01;
		end
	end

	// Pulse stretcher for event-driven resets
	always_ff @(posedge core_clk) begin
		if (rst) begin
			pulseCnt_ff <= 8'h00;
			wakeOnly_ff <= 1'b0;
		end else if (|causeSet) begin
			pulseCnt_ff <= PULSE_CYC;
			wakeOnly_ff <= wakeOnly && debugMode;
		end else if (pulseCnt_ff != 8'h00) begin
			pulseCnt_ff <= pulseCnt_ff - 8'h01;
		end
	end

	// Reset outputs
	always_ff @(posedge core_clk) begin
		if (rst) begin
			systemReset_ff <= 1'b1;
			debugReset_ff <= 1'b1;
		end else begin
			systemReset_ff <= porHold || porCnt_ff != 8'h00 || |causeSet || pulseCnt_ff != 8'h00;
			debugReset_ff <= porHold || porCnt_ff != 8'h00
				|| ((|causeSet && !(wakeOnly && debugMode)) || (pulseCnt_ff != 8'h00 && !wakeOnly_ff));
		end
	end

	// Cause record: set wins over clear; power-on clears all
	always_ff @(posedge core_clk) begin
		if (rst || porHold) begin
			resetCauseRecord_ff <= `CRM_CAUSE_RESET;
		end else begin
			resetCauseRecord_ff <= (resetCauseRecord_ff & ~causeClear) | causeSet;
		end
	end

endmodule
`default_nettype wire

// File: hdl/crm_pkg.sv
// Types for the clock and reset manager
package crm_pkg;
	typedef enum logic [1:0] {
		SLOW_OFF = 2'b00,
		SLOW_WAIT = 2'b01,
		SLOW_RUN = 2'b11,
		SLOW_SWITCH = 2'b10
	} crm_slow_state_t;

	typedef struct packed {
		logic cpuClk;
		logic p1m;
		logic p16m;
		logic p32m;
	} crm_fast_req_t;

	typedef struct packed {
		logic valid;
		logic fromXtal;
	} crm_slow_stat_t;
endpackage

// File: testbench/crm_clock_reset_manager_sva.sv
// Assertion checker for the clock and reset manager
`timescale 1ns/1ps
`default_nettype none
`include "crm_cfg.svh"

module crm_clock_reset_manager_sva (
	input wire logic core_clk, // Clock
	input wire logic rst, // Reset
	input wire crm_pkg::crm_fast_req_t fastReq, // Requests
	input wire logic fastCrystalStartTask, // Start task
	input wire logic fastCrystalStopTask, // Stop task
	input wire logic systemOff, // System OFF
	input wire logic watchdogRunning, // Watchdog active
	input wire logic supplyGood, // Supply good
	input wire logic externalResetPinN, // Reset pin
	input wire logic systemResetRequestBit, // Soft request
	input wire logic fastInternalOn_ff, // Internal osc
	input wire logic fastCrystalOn_ff, // Crystal osc
	input wire crm_pkg::crm_fast_req_t fastGate_ff, // Gates
	input wire logic fastCrystalReadyEvent_ff, // Ready pulse
	input wire logic slowRcOn_ff, // RC enable
	input wire logic slowXtalOn_ff, // Crystal enable
	input wire logic [`CRM_CAUSE_W-1:0] resetCauseRecord_ff, // Causes
	input wire logic systemReset_ff // Reset out
);
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);

	// Fast sources, slow domain and reset generation
	gate_follow_a: assert property (!$past(rst) |-> fastGate_ff == $past(fastReq))
		else $error("gate differs from request");
	fast_off_a: assert property (!$past(rst) && $past(fastReq) == '0 |-> !fastInternalOn_ff)
		else $error("internal osc on without request");
	int_pick_a: assert property (!$past(rst) && $past(fastReq) != '0 && !$past(fastCrystalOn_ff)
		|-> fastInternalOn_ff) else $error("internal osc not used");
	xtal_on_a: assert property (fastCrystalStartTask |=> fastCrystalOn_ff)
		else $error("crystal not started");
	xtal_off_a: assert property (fastCrystalStopTask && !fastCrystalStartTask |=> !fastCrystalOn_ff)
		else $error("crystal not stopped");
	ready_once_a: assert property (fastCrystalReadyEvent_ff |-> $past(fastCrystalOn_ff) ##1 !fastCrystalReadyEvent_ff)
		else $error("ready event malformed");
	slow_off_a: assert property (systemOff [*4] |-> !slowRcOn_ff && !slowXtalOn_ff)
		else $error("slow source on in system off");
	por_hold_a: assert property (!supplyGood [*4] |-> systemReset_ff)
		else $error("reset released with bad supply");
	pin_rst_a: assert property ((!externalResetPinN && supplyGood) [*5]
		|-> systemReset_ff && resetCauseRecord_ff[`CRM_CAUSE_PIN]) else $error("pin reset missed");
	soft_rst_a: assert property (systemResetRequestBit && supplyGood
		|-> ##[1:3] systemReset_ff && resetCauseRecord_ff[`CRM_CAUSE_SOFT]) else $error("soft reset missed");

	// Main scenarios reached
	cover property (fastCrystalReadyEvent_ff);
	cover property (systemResetRequestBit);
	cover property (watchdogRunning && slowRcOn_ff);
endmodule

bind crm_clock_reset_manager crm_clock_reset_manager_sva i_sva (.core_clk, .rst, .fastReq,
	.fastCrystalStartTask, .fastCrystalStopTask, .systemOff, .watchdogRunning, .supplyGood, .externalResetPinN,
	.systemResetRequestBit, .fastInternalOn_ff, .fastCrystalOn_ff, .fastGate_ff, .fastCrystalReadyEvent_ff,
	.slowRcOn_ff, .slowXtalOn_ff, .resetCauseRecord_ff, .systemReset_ff);
`default_nettype wire

// File: testbench/crm_osc_model.sv
// Oscillator model standing beside the clock and reset manager
`timescale 1ns/1ps
`default_nettype none

module crm_osc_model (
	input wire logic clk, // Core clock
	input wire logic xtalOn, // Fast crystal enable
	input wire logic rcOn, // Slow RC enable
	input wire logic sxOn, // Slow crystal enable
	output logic fastStable, // Fast crystal settled
	output logic rcReady, // Slow RC up
	output logic sxReady, // Slow crystal up
	output logic rcTick, // Slow RC clock
	output logic sxTick // Slow crystal clock
);
	int fc = 0;
	int rc = 0;
	int sc = 0;

	// Start-up counters, cleared while a source is off
	always_ff @(posedge clk) begin
		fc <= xtalOn ? fc + 1 : 0;
		rc <= rcOn ? rc + 1 : 0;
		sc <= sxOn ? sc + 1 : 0;
	end

	// Slow crystal settles much later than RC; ticks stand still when off
	assign fastStable = fc > 6;
	assign rcReady = rc > 10;
	assign sxReady = sc > 60;
	assign rcTick = rcReady & rc[3];
	assign sxTick = sxReady & sc[2];
endmodule
`default_nettype wire

// File: testbench/tb_clock_and_reset_manager.sv
// Self-checking testbench for the clock and reset manager
`timescale 1ns/1ps
`default_nettype none
`include "crm_cfg.svh"

module tb_clock_and_reset_manager;
	localparam logic [3:0] PIN = 4'h1 << `CRM_CAUSE_PIN;
	localparam logic [3:0] WDG = 4'h1 << `CRM_CAUSE_WDOG;
	localparam logic [3:0] SFT = 4'h1 << `CRM_CAUSE_SOFT;
	localparam logic [3:0] WAK = 4'h1 << `CRM_CAUSE_WAKE;
	logic core_clk = 1'b0, rst = 1'b1, supplyGood = 1'b1, regulatorsUp = 1'b1, externalResetPinN = 1'b1;
	logic fastCrystalStartTask = 1'b0, fastCrystalStopTask = 1'b0, slowClockStartTask = 1'b0;
	logic slowClockStopTask = 1'b0, slowSourceSelectWr = 1'b0, slowSourceSelectIn = 1'b0;
	logic watchdogRunning = 1'b0, modemNeedsSlow = 1'b0, systemOff = 1'b0, debugMode = 1'b0;
	logic brownoutActive = 1'b0, brownoutSleep = 1'b0, wakeupEvent = 1'b0;
	logic systemResetRequestBit = 1'b0, watchdogTimeout = 1'b0;
	logic [3:0] causeClear = 4'h0, slowEvents = 4'h0, fastEvents = 4'h0;
	crm_pkg::crm_fast_req_t fastReq = '0, fastGate_ff;
	crm_pkg::crm_slow_stat_t slowClockStatus_ff;
	logic fastCrystalStable, slowRcReady, slowXtalReady, slowRcTick, slowXtalTick;
	logic fastInternalOn_ff, fastCrystalOn_ff, fastCrystalReadyEvent_ff, slowRcOn_ff, slowXtalOn_ff;
	logic slowClockOut_ff, slowClockReadyEvent_ff, slowSourceSelect_ff, systemReset_ff, debugReset_ff;
	logic [3:0] resetCauseRecord_ff;
	int nErrors = 0, comparisons = 0;

	crm_clock_reset_manager i_dut (.core_clk, .rst, .fastReq, .fastCrystalStartTask, .fastCrystalStopTask,
		.fastCrystalStable, .slowClockStartTask, .slowClockStopTask, .slowSourceSelectWr, .slowSourceSelectIn,
		.slowRcReady, .slowXtalReady, .slowRcTick, .slowXtalTick, .watchdogRunning, .modemNeedsSlow,
		.systemOff, .debugMode, .supplyGood, .regulatorsUp, .brownoutActive, .brownoutSleep,
		.externalResetPinN, .wakeupEvent, .systemResetRequestBit, .watchdogTimeout, .causeClear,
		.fastInternalOn_ff, .fastCrystalOn_ff, .fastGate_ff, .fastCrystalReadyEvent_ff, .slowRcOn_ff,
		.slowXtalOn_ff, .slowClockOut_ff, .slowClockReadyEvent_ff, .slowClockStatus_ff, .slowSourceSelect_ff,
		.resetCauseRecord_ff, .systemReset_ff, .debugReset_ff);

	crm_osc_model i_osc (.clk(core_clk), .xtalOn(fastCrystalOn_ff), .rcOn(slowRcOn_ff), .sxOn(slowXtalOn_ff),
		.fastStable(fastCrystalStable), .rcReady(slowRcReady), .sxReady(slowXtalReady),
		.rcTick(slowRcTick), .sxTick(slowXtalTick));

	// Clock and event counters
	initial forever #20 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		if (rst) begin
			slowEvents <= 4'h0;
			fastEvents <= 4'h0;
		end else begin
			slowEvents <= slowEvents + 4'(slowClockReadyEvent_ff);
			fastEvents <= fastEvents + 4'(fastCrystalReadyEvent_ff);
		end
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic chk(input string name, input logic [3:0] exp, input logic [3:0] got);
		comparisons++;
		if (got !== exp) begin
			nErrors++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge core_clk);
	endtask
	task automatic pulse(ref logic s);
		s = 1'b1;
		cyc(1);
		s = 1'b0;
	endtask
	task automatic finishTest();
		if (nErrors == 0 && comparisons > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic doReset();
		cyc(16);
		rst = 1'b0;
		cyc(10);
		chk("porHold", 1'b1, systemReset_ff);
		for (int i = 0; i < 60 && systemReset_ff !== 1'b0; i++) cyc(1);
		chk("causesAtStart", 4'h0, resetCauseRecord_ff);
		chk("slowSelect", `CRM_SRC_RESET, slowSourceSelect_ff);
	endtask
	task automatic tFast();
		for (int b = 0; b < 4; b++) begin
			fastReq = 4'h1 << b;
			cyc(2);
			chk("fastGate", 4'h1 << b, fastGate_ff);
			chk("internalOn", 1'b1, fastInternalOn_ff);
		end
		fastReq = '0;
		cyc(2);
		chk("gatesOff", 4'h0, fastGate_ff);
		chk("internalOff", 1'b0, fastInternalOn_ff);
	endtask
	task automatic tXtal();
		fastReq = 4'h8;
		pulse(fastCrystalStartTask);
		chk("xtalOn", 1'b1, fastCrystalOn_ff);
		cyc(30);
		chk("fastEvents", 4'h1, fastEvents);
		chk("internalIdle", 1'b0, fastInternalOn_ff);
		pulse(fastCrystalStopTask);
		chk("xtalOff", 1'b0, fastCrystalOn_ff);
		cyc(3);
		chk("internalBack", 1'b1, fastInternalOn_ff);
		fastReq = '0;
	endtask
	task automatic tSlow();
		pulse(slowClockStartTask);
		for (int i = 0; i < 80 && slowClockStatus_ff.valid !== 1'b1; i++) cyc(1);
		cyc(3);
		chk("slowEvents", 4'h1, slowEvents);
		chk("fromRc", 1'b0, slowClockStatus_ff.fromXtal);
		for (int i = 0; i < 20 && slowClockOut_ff !== 1'b1; i++) cyc(1);
		chk("slowClockHigh", 1'b1, slowClockOut_ff);
		slowSourceSelectIn = `CRM_SRC_XTAL;
		pulse(slowSourceSelectWr);
		pulse(slowClockStartTask);
		cyc(4);
		chk("keepRunning", 1'b1, slowClockStatus_ff.valid);
		chk("rcQuality", 1'b0, slowClockStatus_ff.fromXtal);
		for (int i = 0; i < 300 && slowClockStatus_ff.fromXtal !== 1'b1; i++) cyc(1);
		chk("switched", 1'b1, slowClockStatus_ff.fromXtal);
		chk("xtalSrcOn", 1'b1, slowXtalOn_ff);
		modemNeedsSlow = 1'b1;
		pulse(slowClockStopTask);
		cyc(20);
		chk("modemHolds", 1'b1, slowClockStatus_ff.valid);
		modemNeedsSlow = 1'b0;
		cyc(20);
		chk("slowStopped", 1'b0, slowClockStatus_ff.valid);
		chk("xtalSrcOff", 1'b0, slowXtalOn_ff);
	endtask
	task automatic tOff();
		watchdogRunning = 1'b1;
		for (int i = 0; i < 40 && slowRcOn_ff !== 1'b1; i++) cyc(1);
		chk("wdogStartsRc", 1'b1, slowRcOn_ff);
		systemOff = 1'b1;
		cyc(6);
		chk("rcOffInSleep", 1'b0, slowRcOn_ff);
		chk("slowOutInSleep", 1'b0, slowClockOut_ff);
		pulse(watchdogTimeout);
		cyc(2);
		chk("noWdogInSleep", 4'h0, resetCauseRecord_ff);
		debugMode = 1'b1;
		pulse(wakeupEvent);
		cyc(1);
		chk("wakeReset", 1'b1, systemReset_ff);
		chk("debugKept", 1'b0, debugReset_ff);
		chk("wakeCause", WAK, resetCauseRecord_ff);
		systemOff = 1'b0;
		watchdogRunning = 1'b0;
		debugMode = 1'b0;
		causeClear = WAK;
		cyc(1);
		causeClear = 4'h0;
		cyc(8);
		chk("wakeCleared", 4'h0, resetCauseRecord_ff);
		chk("resetDone", 1'b0, systemReset_ff);
	endtask
	task automatic tResets();
		externalResetPinN = 1'b0;
		cyc(6);
		chk("pinReset", 1'b1, systemReset_ff);
		externalResetPinN = 1'b1;
		cyc(4);
		chk("pinCause", PIN, resetCauseRecord_ff);
		pulse(systemResetRequestBit);
		pulse(watchdogTimeout);
		cyc(2);
		chk("accumulated", PIN | SFT | WDG, resetCauseRecord_ff);
		causeClear = PIN | SFT;
		cyc(1);
		chk("partClear", WDG, resetCauseRecord_ff);
		causeClear = WDG;
		cyc(1);
		causeClear = 4'h0;
		cyc(8);
		chk("allClear", 4'h0, resetCauseRecord_ff);
	endtask
	task automatic tPower();
		brownoutSleep = 1'b1;
		cyc(5);
		chk("sleepLevelIgnored", 1'b0, systemReset_ff);
		brownoutSleep = 1'b0;
		pulse(systemResetRequestBit);
		brownoutActive = 1'b1;
		cyc(4);
		chk("brownout", 1'b1, systemReset_ff);
		brownoutActive = 1'b0;
		cyc(10);
		chk("brownHold", 1'b1, systemReset_ff);
		for (int i = 0; i < 60 && systemReset_ff !== 1'b0; i++) cyc(1);
		chk("onChipCause", 4'h0, resetCauseRecord_ff);
		supplyGood = 1'b0;
		cyc(4);
		chk("supplyHold", 1'b1, systemReset_ff);
		supplyGood = 1'b1;
		for (int i = 0; i < 60 && systemReset_ff !== 1'b0; i++) cyc(1);
		chk("supplyRelease", 1'b0, systemReset_ff);
	endtask

	// Main sequence and watchdog
	initial begin
		doReset();
		tFast();
		tXtal();
		tSlow();
		tOff();
		tResets();
		tPower();
		finishTest();
	end
	initial begin
		#200000;
		nErrors++;
		finishTest();
	end
endmodule
`default_nettype wire
